// File: rtl/omtr_pkg.sv
// Package: shared constants for the output mode and thermal relay block
package omtr_pkg;

    // ----------------------------------------
    // Register word addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_OUTPUT_CONTROL_WORD = 8'h02;
    localparam logic [7:0] ADDR_ZONE1_FILTERED_IR = 8'h04;
    localparam logic [7:0] ADDR_ZONE2_FILTERED_IR = 8'h05;
    localparam logic [7:0] ADDR_DIE_TEMPERATURE_RESULT = 8'h06;
    localparam logic [7:0] ADDR_OBJECT_ZONE1_RESULT = 8'h07;
    localparam logic [7:0] ADDR_OBJECT_ZONE2_RESULT = 8'h08;
    localparam logic [7:0] ADDR_RELAY_HYSTERESIS = 8'h20;
    localparam logic [7:0] ADDR_RELAY_THRESHOLD = 8'h21;

    // ----------------------------------------
    // Output control word fields
    // ----------------------------------------
    localparam int BIT_OUTPUT_ENABLE = 1;
    localparam int BIT_OUTPUT_DRIVE_TYPE = 2;
    localparam int BIT_RELAY_SELECT = 3;
    localparam int BIT_DUAL_SENSOR = 4;

    // ----------------------------------------
    // Value limits
    // ----------------------------------------
    localparam logic [15:0] DIE_TEMP_MIN = 16'h2DE4;
    localparam logic [15:0] DIE_TEMP_MAX = 16'h4DC4;
    localparam logic [15:0] OBJ_TEMP_MAX = 16'h7FFF;
    localparam logic [15:0] OBJ_ERROR_FLAG = 16'h8000;
    localparam logic [15:0] HYST_MIN = 16'h0001;
    localparam int PWM_WORD_BITS = 10;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_FREQ_HZ = 200000000;
    localparam int REQ_TIME_NS = 1440000;
    // Longest low that is not yet a request: round down, then exceed it
    localparam int REQ_CYCLES = (REQ_TIME_NS / 5);
    localparam int REQ_CNT_BITS = 19;
    // Host divider: half period of the host serial clock, and its hold
    localparam int HOST_HALF_CYCLES = 6;
    localparam int HOST_REQ_CYCLES = REQ_CYCLES + 2000;

    // ----------------------------------------
    // Device states
    // ----------------------------------------
    typedef enum logic [1:0] {
        OMTR_ST_LOAD = 2'b00,
        OMTR_ST_PWM = 2'b01,
        OMTR_ST_SMBUS = 2'b10
    } omtr_mode_t;

endpackage

// File: rtl/omtr_if.sv
// Interface: shared clock line and shared data/output pin between the ends
`timescale 1ns/1ps
interface omtr_if;
    logic scl_out;
    logic scl_oe;
    logic sda_dev_out;
    logic sda_dev_oe;
    logic sda_host_out;
    logic sda_host_oe;
    logic scl_in;
    logic sda_in;

    // Pull-up resolution: any enabled driver at low pulls the wire low
    assign scl_in = !(scl_oe && !scl_out);
    assign sda_in = !((sda_dev_oe && !sda_dev_out) ||
                      (sda_host_oe && !sda_host_out));

    modport device (
        input scl_in,
        input sda_in,
        output sda_dev_out,
        output sda_dev_oe
    );

    modport host (
        input scl_in,
        input sda_in,
        output scl_out,
        output scl_oe,
        output sda_host_out,
        output sda_host_oe
    );
endinterface

// File: rtl/omtr_relay_cmp.sv
// Relay comparator with threshold and hysteresis on the zone-1 result
`timescale 1ns/1ps
module omtr_relay_cmp (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Operands
    input wire logic sample_valid,
    input wire logic [15:0] object_zone1_temp,
    input wire logic [15:0] relay_threshold,
    input wire logic [15:0] relay_hysteresis,
    // Result
    output logic relay_level
);
    // Switching points widened to 17 bits so sums never wrap
    wire [16:0] upper_point = {1'b0, relay_threshold} +
                              {1'b0, relay_hysteresis};
    wire [16:0] lower_point = {1'b0, relay_threshold} -
                              {1'b0, relay_hysteresis};
    wire lower_wrapped = relay_hysteresis > relay_threshold;
    wire [16:0] temp_ext = {1'b0, object_zone1_temp};
    wire go_high = temp_ext >= upper_point;
    wire go_low = !lower_wrapped && (temp_ext <= lower_point);
    logic next_relay_level;

    // Between the points the old level stays put
    always_comb begin
        next_relay_level = relay_level;
        if (sample_valid && go_high) begin
            next_relay_level = 1'b1;
        end else if (sample_valid && go_low) begin
            next_relay_level = 1'b0;
        end
    end

    // Relay state register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            relay_level <= 1'b0;
        end else begin
            relay_level <= next_relay_level;
        end
    end
endmodule

// File: rtl/omtr_device.sv
// Device end: output mode selection, request detect, results and relay
//
// Summary of operation
// - Host keeps clock high during pulse output
// - Request before SMBus hands pin to data
// - Only reset or sleep exit re-enables output
// - Request is clock low beyond 1.44 ms
// - Data level ignored during request detection
// - Output disabled: pin is SMBus from reset
// - Host sends no request when output disabled
// - Die temperature word 0x06, clamped range
// - Object results unsigned kelvin 0.02 K
// - Object word MSB flags error, max 0x7FFF
// - Load configuration then loop continuously
// - Zone 1 results to words 0x04, 0x07
// - Zone 2 results to words 0x05, 0x08
// - Single sensor skips zone 2 step
// - Each loop loads 10-bit pulse word
// - Comparator input is zone-1 object only
// - Relay needs relay select and output enable
// - One driver serves pulse and relay
// - Drive type bit picks push-pull/open-drain
// - Threshold word 0x21, hysteresis word 0x20
// - High at threshold+hyst, low at threshold-hyst
// - Relay keeps measuring, readable after request
// - Hysteresis 0.01 per LSB, minimum 0x0001
`timescale 1ns/1ps
module omtr_device (
    // Clock and reset (power-on or sleep exit)
    input wire logic sys_clk,
    input wire logic srst,
    // Link
    omtr_if.device link,
    // Nonvolatile configuration write port
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    // Raw measurement results from the signal core
    input wire logic meas_valid,
    input wire logic [15:0] meas_ir1,
    input wire logic [15:0] meas_ir2,
    input wire logic [15:0] meas_die,
    input wire logic [15:0] meas_obj1,
    input wire logic [15:0] meas_obj2,
    input wire logic meas_err1,
    input wire logic meas_err2,
    // Result read port
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    // Status
    output logic smbus_active,
    output logic relay_mode,
    output logic [9:0] pwm_word,
    output logic pwm_load
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0] output_control_word;
    logic [15:0] relay_hysteresis;
    logic [15:0] relay_threshold;
    logic [15:0] result_ram [4:8];
    omtr_pkg::omtr_mode_t mode;
    omtr_pkg::omtr_mode_t next_mode;
    logic scl_meta;
    logic scl_sync;
    logic [18:0] low_count;
    logic relay_level;
    logic zone2_pending;

    // Clamp a die value into its linearisation limits
    function automatic logic [15:0] clamp_die(input logic [15:0] v);
        if (v < omtr_pkg::DIE_TEMP_MIN) begin
            clamp_die = omtr_pkg::DIE_TEMP_MIN;
        end else if (v > omtr_pkg::DIE_TEMP_MAX) begin
            clamp_die = omtr_pkg::DIE_TEMP_MAX;
        end else begin
            clamp_die = v;
        end
    endfunction

    // Object word: 15-bit kelvin value plus error flag in the MSB
    function automatic logic [15:0] obj_word(input logic [15:0] v,
                                             input logic err);
        obj_word = err ? (v | omtr_pkg::OBJ_ERROR_FLAG)
                       : (v & omtr_pkg::OBJ_TEMP_MAX);
    endfunction

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    wire output_enable = output_control_word[omtr_pkg::BIT_OUTPUT_ENABLE];
    wire drive_push_pull =
        output_control_word[omtr_pkg::BIT_OUTPUT_DRIVE_TYPE];
    wire relay_select_bit = output_control_word[omtr_pkg::BIT_RELAY_SELECT];
    wire dual_sensor = output_control_word[omtr_pkg::BIT_DUAL_SENSOR];
    wire relay_cfg = relay_select_bit && output_enable;
    // Zero hysteresis is not usable; treat it as the smallest step
    wire [15:0] hyst_eff = (relay_hysteresis < omtr_pkg::HYST_MIN) ?
                           omtr_pkg::HYST_MIN : relay_hysteresis;
    wire req_seen = (low_count > 19'(omtr_pkg::REQ_CYCLES));
    wire pin_level = relay_cfg ? relay_level : pwm_word[0];

    // ----------------------------------------
    // Clock line synchroniser and request timer
    // ----------------------------------------
    // Data line is never looked at here, only the clock line
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            low_count <= '0;
        end else begin
            scl_meta <= link.scl_in;
            scl_sync <= scl_meta;
            if (scl_sync || mode != omtr_pkg::OMTR_ST_PWM) begin
                low_count <= '0;
            end else if (!req_seen) begin
                low_count <= low_count + 19'h00001;
            end
        end
    end

    // ----------------------------------------
    // Mode machine
    // ----------------------------------------
    always_comb begin
        next_mode = mode;
        unique case (mode)
            omtr_pkg::OMTR_ST_LOAD: begin
                if (output_enable) begin
                    next_mode = omtr_pkg::OMTR_ST_PWM;
                end else begin
                    next_mode = omtr_pkg::OMTR_ST_SMBUS;
                end
            end
            omtr_pkg::OMTR_ST_PWM: begin
                if (req_seen) begin
                    next_mode = omtr_pkg::OMTR_ST_SMBUS;
                end
            end
            omtr_pkg::OMTR_ST_SMBUS: begin
                next_mode = omtr_pkg::OMTR_ST_SMBUS;
            end
            default: begin
                next_mode = omtr_pkg::OMTR_ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode <= omtr_pkg::OMTR_ST_LOAD;
        end else begin
            mode <= next_mode;
        end
    end

    // ----------------------------------------
    // Nonvolatile words; configuration keeps its value over reset
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (cfg_we && cfg_addr == omtr_pkg::ADDR_OUTPUT_CONTROL_WORD) begin
            output_control_word <= cfg_wdata;
        end
        if (cfg_we && cfg_addr == omtr_pkg::ADDR_RELAY_HYSTERESIS) begin
            relay_hysteresis <= cfg_wdata;
        end
        if (cfg_we && cfg_addr == omtr_pkg::ADDR_RELAY_THRESHOLD) begin
            relay_threshold <= cfg_wdata;
        end
    end

    // ----------------------------------------
    // Result RAM: zone 1 every loop, zone 2 one cycle later if dual
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            zone2_pending <= 1'b0;
            pwm_load <= 1'b0;
            pwm_word <= '0;
        end else begin
            pwm_load <= 1'b0;
            zone2_pending <= 1'b0;
            if (meas_valid && mode != omtr_pkg::OMTR_ST_LOAD) begin
                result_ram[6] <= clamp_die(meas_die);
                result_ram[4] <= meas_ir1;
                result_ram[7] <= obj_word(meas_obj1, meas_err1);
                zone2_pending <= dual_sensor;
                // Top ten bits stand in for the rescaled pulse word
                pwm_word <= meas_obj1[14:5];
                pwm_load <= 1'b1;
            end
            if (zone2_pending) begin
                result_ram[5] <= meas_ir2;
                result_ram[8] <= obj_word(meas_obj2, meas_err2);
            end
        end
    end

    // ----------------------------------------
    // Relay comparator fed from the stored zone-1 result
    // ----------------------------------------
    omtr_relay_cmp u_cmp (
        .sys_clk(sys_clk),
        .srst(srst),
        .sample_valid(pwm_load),
        .object_zone1_temp(result_ram[7]),
        .relay_threshold(relay_threshold),
        .relay_hysteresis(hyst_eff),
        .relay_level(relay_level)
    );

    // ----------------------------------------
    // Shared pin driver and read port
    // ----------------------------------------
    wire rd_hit = (rd_addr >= omtr_pkg::ADDR_ZONE1_FILTERED_IR) &&
                  (rd_addr <= omtr_pkg::ADDR_OBJECT_ZONE2_RESULT);
    wire [15:0] rd_mux = rd_hit ? result_ram[rd_addr] : 16'h0000;
    wire drive_active = (mode == omtr_pkg::OMTR_ST_PWM);
    // Open-drain only pulls low; push-pull drives both levels
    wire next_oe = drive_active &&
                   (drive_push_pull || !pin_level);
    wire next_smbus = (next_mode == omtr_pkg::OMTR_ST_SMBUS);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.sda_dev_out <= 1'b0;
            link.sda_dev_oe <= 1'b0;
            rd_data <= '0;
            smbus_active <= 1'b0;
            relay_mode <= 1'b0;
        end else begin
            link.sda_dev_out <= pin_level;
            link.sda_dev_oe <= next_oe;
            rd_data <= rd_mux;
            smbus_active <= next_smbus;
            relay_mode <= relay_cfg && drive_active;
        end
    end
endmodule

// File: rtl/omtr_host.sv
// Host end: holds the clock high, or forms the request condition
`timescale 1ns/1ps
module omtr_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Link
    omtr_if.host link,
    // User side
    input wire logic req_start,
    input wire logic pwm_cfg_enabled,
    output logic req_done,
    output logic sda_level
);
    // ----------------------------------------
    // Request timer
    // ----------------------------------------
    logic [18:0] hold_count;
    logic busy;
    logic sda_meta;

    // A request is refused while the device has no pulse output
    wire start_ok = req_start && pwm_cfg_enabled && !busy;
    wire hold_end = busy &&
        (hold_count == 19'(omtr_pkg::HOST_REQ_CYCLES));

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy <= 1'b0;
            hold_count <= '0;
            req_done <= 1'b0;
            link.scl_out <= 1'b1;
            link.scl_oe <= 1'b0;
            link.sda_host_out <= 1'b1;
            link.sda_host_oe <= 1'b0;
            sda_meta <= 1'b1;
            sda_level <= 1'b1;
        end else begin
            sda_meta <= link.sda_in;
            sda_level <= sda_meta;
            req_done <= hold_end;
            if (start_ok) begin
                busy <= 1'b1;
                hold_count <= '0;
            end else if (hold_end) begin
                busy <= 1'b0;
            end else if (busy) begin
                hold_count <= hold_count + 19'h00001;
            end
            // Clock line high (released) except during the request
            link.scl_out <= 1'b0;
            link.scl_oe <= start_ok || (busy && !hold_end);
            link.sda_host_oe <= 1'b0;
        end
    end
endmodule

// File: tb/omtr_monitor.sv
// Checker: concurrent assertions on the link and the device status
`timescale 1ns/1ps
module omtr_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Link wires
    input wire logic scl_in,
    input wire logic sda_dev_oe,
    // Device status
    input wire logic smbus_active,
    input wire logic relay_mode,
    input wire logic pwm_load
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic [18:0] low_cnt;
    logic [2:0] rst_age;

    // Length of the current low run on the clock line, saturating
    always_ff @(posedge sys_clk) begin
        if (srst || scl_in) begin
            low_cnt <= '0;
        end else if (low_cnt != '1) begin
            low_cnt <= low_cnt + 19'h00001;
        end
    end

    // Cycles since reset release; the first edges may still be loading
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rst_age <= '0;
        end else if (rst_age != 3'h7) begin
            rst_age <= rst_age + 3'h1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Two sync flops plus the answer latency leave a margin of ten
    a_req_switch: assert property (
        (int'(low_cnt) == omtr_pkg::REQ_CYCLES + 10) |-> smbus_active)
        else $error("link not handed over after a long clock low");
    a_no_early_switch: assert property (
        $rose(smbus_active) |->
        (rst_age < 3'h4 || int'(low_cnt) > omtr_pkg::REQ_CYCLES))
        else $error("link handed over without a request");
    a_smbus_quiet: assert property (
        smbus_active |=> !sda_dev_oe)
        else $error("pin still driven after hand-over");
    a_smbus_sticky: assert property (
        smbus_active |=> smbus_active)
        else $error("output mode came back without reset");
    a_reset_quiet: assert property (
        $fell(srst) |-> (!sda_dev_oe && !smbus_active && !relay_mode))
        else $error("outputs active right after reset");
    a_mode_fixed: assert property (
        (rst_age == 3'h7 && !smbus_active) |-> $stable(relay_mode))
        else $error("relay mode changed during the run");
    a_req_span: assert property (
        $rose(scl_in) |-> int'(low_cnt) > omtr_pkg::REQ_CYCLES)
        else $error("clock low run too short for a request");
    a_load_pulse: assert property (
        pwm_load |=> !pwm_load)
        else $error("pulse word load longer than one cycle");
endmodule

// File: tb/tb_output_mode_and_thermal_relay.sv
// Testbench: both ends joined over the link, driven at their user sides
`timescale 1ns/1ps
module tb_output_mode_and_thermal_relay;
    // ----------------------------------------
    // Stimulus and counters
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    int n_errors = 0;
    int n_checks = 0;
    logic cfg_we = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [15:0] cfg_wdata = 16'h0000;
    logic meas_valid = 1'b0;
    logic [15:0] meas_ir1 = 16'h0000;
    logic [15:0] meas_ir2 = 16'h0000;
    logic [15:0] meas_die = 16'h0000;
    logic [15:0] meas_obj1 = 16'h0000;
    logic [15:0] meas_obj2 = 16'h0000;
    logic meas_err1 = 1'b0;
    logic meas_err2 = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [15:0] rd_data;
    logic smbus_active;
    logic relay_mode;
    logic [9:0] pwm_word;
    logic pwm_load;
    logic req_start = 1'b0;
    logic pwm_cfg_enabled = 1'b0;
    logic req_done;
    logic sda_level;
    // Zone-1 steps across both switching points, with the pin level each
    logic [15:0] objs [5] = '{16'h6C43, 16'h6D0A, 16'h6D0B, 16'h6C44,
                              16'h6C43};
    logic [15:0] lvls [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001,
                              16'h0000};

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    omtr_if omtr_if_i ();
    omtr_device omtr_device_i (.sys_clk(sys_clk), .srst(srst),
        .link(omtr_if_i.device), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .meas_valid(meas_valid), .meas_ir1(meas_ir1),
        .meas_ir2(meas_ir2), .meas_die(meas_die), .meas_obj1(meas_obj1),
        .meas_obj2(meas_obj2), .meas_err1(meas_err1), .meas_err2(meas_err2),
        .rd_addr(rd_addr), .rd_data(rd_data), .smbus_active(smbus_active),
        .relay_mode(relay_mode), .pwm_word(pwm_word), .pwm_load(pwm_load));
    omtr_host omtr_host_i (.sys_clk(sys_clk), .srst(srst),
        .link(omtr_if_i.host), .req_start(req_start),
        .pwm_cfg_enabled(pwm_cfg_enabled), .req_done(req_done),
        .sda_level(sda_level));
    omtr_monitor omtr_monitor_i (.sys_clk(sys_clk), .srst(srst),
        .scl_in(omtr_if_i.scl_in), .sda_dev_oe(omtr_if_i.sda_dev_oe),
        .smbus_active(smbus_active), .relay_mode(relay_mode),
        .pwm_load(pwm_load));

    // Single-bit link and status values widened for the compare task
    wire [15:0] pin_word = {15'h0000, omtr_if_i.sda_in};
    wire [15:0] oe_word = {15'h0000, omtr_if_i.sda_dev_oe};
    wire [15:0] smbus_word = {15'h0000, smbus_active};

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        cfg_we = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_we = 1'b0;
    endtask

    // Config words survive reset, so they are written while it is held
    task automatic restart(input logic [15:0] ctrl);
        srst = 1'b1;
        cfg_write(omtr_pkg::ADDR_OUTPUT_CONTROL_WORD, ctrl);
        cfg_write(omtr_pkg::ADDR_RELAY_HYSTERESIS, 16'h0064);
        cfg_write(omtr_pkg::ADDR_RELAY_THRESHOLD, 16'h6CA7);
        pwm_cfg_enabled = ctrl[omtr_pkg::BIT_OUTPUT_ENABLE];
        // Six cycles of writes plus six more make twelve in reset
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic rd(input string name, input logic [7:0] a,
                      input logic [15:0] exp);
        @(negedge sys_clk);
        rd_addr = a;
        @(negedge sys_clk);
        check(name, rd_data, exp);
    endtask

    // One loop's results; zone-2 values stay put for the second edge
    task automatic measure(input logic [15:0] o1, input logic [15:0] o2,
                           input logic e1, input logic [15:0] die);
        @(negedge sys_clk);
        meas_valid = 1'b1;
        meas_obj1 = o1;
        meas_obj2 = o2;
        meas_err1 = e1;
        meas_die = die;
        meas_ir1 = o1 ^ 16'h5A5A;
        meas_ir2 = o2 ^ 16'hA5A5;
        @(negedge sys_clk);
        meas_valid = 1'b0;
        // The load strobe stands one cycle only, so look at it now
        check("pwm_load", {15'h0000, pwm_load}, 16'h0001);
        check("pwm_word", {6'h00, pwm_word}, {6'h00, o1[14:5]});
        // Relay level moves on the next edge, the pin one edge later
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        // Output disabled: data pin belongs to the serial bus at once
        restart(16'h0008);
        check("smbus_active", smbus_word, 16'h0001);
        check("relay_mode", {15'h0000, relay_mode}, 16'h0000);
        // The host refuses a request here, so the clock line stays high
        @(negedge sys_clk);
        req_start = 1'b1;
        @(negedge sys_clk);
        req_start = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("scl idle", {15'h0000, omtr_if_i.scl_in}, 16'h0001);
        check("req_done idle", {15'h0000, req_done}, 16'h0000);
        $display("test disabled done");
        // Relay, push-pull, two zones: result words and switching points
        restart(16'h001E);
        check("relay_mode", {15'h0000, relay_mode}, 16'h0001);
        measure(16'h1234, 16'h0BCD, 1'b1, 16'h1000);
        rd("ir1", 8'h04, 16'h1234 ^ 16'h5A5A);
        rd("obj1 err", 8'h07, 16'h9234);
        rd("ir2", 8'h05, 16'h0BCD ^ 16'hA5A5);
        rd("obj2", 8'h08, 16'h0BCD);
        rd("die low", 8'h06, omtr_pkg::DIE_TEMP_MIN);
        rd("unmapped", 8'h03, 16'h0000);
        measure(16'hFFFF, 16'h0000, 1'b0, 16'hFFFF);
        rd("obj1 max", 8'h07, 16'h7FFF);
        rd("die high", 8'h06, omtr_pkg::DIE_TEMP_MAX);
        // Zone 2 sits at the far extreme and must not steer the relay
        foreach (objs[i]) begin
            measure(objs[i], 16'h7FFF, 1'b0, 16'h3A00);
            check("relay pin", pin_word, lvls[i]);
            check("push-pull oe", oe_word, 16'h0001);
        end
        rd("die mid", 8'h06, 16'h3A00);
        $display("test relay done");
        // Open drain, then a request hands the pin to the serial bus
        restart(16'h000A);
        measure(16'h6D0B, 16'h0000, 1'b0, 16'h3A00);
        check("od high oe", oe_word, 16'h0000);
        check("od high pin", pin_word, 16'h0001);
        measure(16'h6C43, 16'h0000, 1'b0, 16'h3A00);
        check("od low pin", pin_word, 16'h0000);
        check("host sees pin", {15'h0000, sda_level}, 16'h0000);
        @(negedge sys_clk);
        req_start = 1'b1;
        @(negedge sys_clk);
        req_start = 1'b0;
        // Data line stays low until the hand-over and must not matter
        for (int i = 0; i < 300000 && req_done !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        check("req_done", {15'h0000, req_done}, 16'h0001);
        repeat (2) @(negedge sys_clk);
        check("smbus_active", smbus_word, 16'h0001);
        check("pin released", pin_word, 16'h0001);
        check("host released", {15'h0000, sda_level}, 16'h0001);
        measure(16'h6C40, 16'h0000, 1'b0, 16'h3A00);
        check("oe after req", oe_word, 16'h0000);
        rd("obj1 readable", 8'h07, 16'h6C40);
        // Single sensor: zone-2 word keeps the relay test's last value
        rd("obj2 kept", 8'h08, 16'h7FFF);
        $display("test request done");
        // Only a reset brings the relay output back
        restart(16'h000A);
        check("smbus after rst", smbus_word, 16'h0000);
        measure(16'h6C43, 16'h0000, 1'b0, 16'h3A00);
        check("oe after rst", oe_word, 16'h0001);
        $display("test re-enable done");
        print_verdict();
    end

    // Watchdog: the request alone takes about 290000 cycles
    initial begin
        repeat (400000) @(posedge sys_clk);
        n_errors++;
        $display("unexpected watchdog: expected finish seen hang");
        print_verdict();
    end
endmodule
